/* logic/bm_pkg.sv */
// Constants and types shared by the bus matrix arbiter.
package bm_pkg;

    localparam int NUM_M   = 16;
    localparam int NUM_S   = 16;
    localparam int IDX_W   = 4;
    localparam int PRI_W   = 4;
    localparam int SLOT_W  = 8;
    localparam int BEAT_W  = 4;
    localparam int ADDR_W  = 32;
    localparam int REG_W   = 32;
    localparam int PRI_PER = 8;
    localparam int REG_HI  = 31;
    localparam int REG_LO  = 28;

    localparam logic [3:0] REGION_BOOT    = 4'h0;
    localparam logic [3:0] BOOT_INT_SLAVE = 4'h0;
    localparam logic [3:0] BOOT_EXT_SLAVE = 4'hE;
    localparam logic [3:0] REMAP_SLAVE    = 4'h1;

    typedef enum logic [1:0] {
        TR_IDLE   = 2'h0,
        TR_BUSY   = 2'h1,
        TR_NONSEQ = 2'h2,
        TR_SEQ    = 2'h3
    } trans_e;

    localparam logic [2:0] BURST_SINGLE = 3'h0;
    localparam logic [2:0] BURST_INCR   = 3'h1;
    localparam logic [2:0] BURST_WRAP4  = 3'h2;
    localparam logic [2:0] BURST_INCR4  = 3'h3;
    localparam logic [2:0] BURST_WRAP8  = 3'h4;
    localparam logic [2:0] BURST_INCR8  = 3'h5;

    typedef enum logic [2:0] {
        LIMIT_INFINITE = 3'h0,
        LIMIT_ONE      = 3'h1,
        LIMIT_FOUR     = 3'h2,
        LIMIT_EIGHT    = 3'h3,
        LIMIT_SIXTEEN  = 3'h4
    } limit_e;

    typedef enum logic [1:0] {
        DEF_NONE  = 2'h0,
        DEF_LAST  = 2'h1,
        DEF_FIXED = 2'h2
    } policy_e;

    localparam logic ARB_ROUND_ROBIN = 1'b0;
    localparam logic ARB_FIXED_PRIO  = 1'b1;

    localparam logic [3:0] MASK_1  = 4'h0;
    localparam logic [3:0] MASK_4  = 4'h3;
    localparam logic [3:0] MASK_8  = 4'h7;
    localparam logic [3:0] MASK_16 = 4'hF;

    localparam logic [SLOT_W-1:0] SLOT_ZERO = 8'h00;
    localparam logic [SLOT_W-1:0] SLOT_ONE  = 8'h01;
    localparam logic [BEAT_W-1:0] BEAT_ZERO = 4'h0;
    localparam logic [BEAT_W-1:0] BEAT_ONE  = 4'h1;
    localparam logic [IDX_W-1:0]  IDX_ONE   = 4'h1;

endpackage : bm_pkg

/* logic/bus_matrix.sv */
// Multi-layer bus matrix: per-master decoders and per-slave arbiters.
`timescale 1ns/1ns
module bus_matrix (
    // Clock and reset
    input  wire logic                                          clk_sys,
    input  wire logic                                          srst,
    // Power management
    input  wire logic                                          clk_stop_req,
    input  wire logic                                          matrix_en,
    output logic                                               clk_run,
    output logic                                               matrix_quiet,
    // Master requests
    input  wire logic [bm_pkg::NUM_M-1:0][1:0]                 m_trans,
    input  wire logic [bm_pkg::NUM_M-1:0][2:0]                 m_burst,
    input  wire logic [bm_pkg::NUM_M-1:0][bm_pkg::ADDR_W-1:0]  m_addr,
    output logic      [bm_pkg::NUM_M-1:0]                      m_ready,
    // Master configuration
    input  wire logic                                          boot_ext_sel,
    input  wire logic [bm_pkg::NUM_M-1:0]                      master_remap_control,
    input  wire logic [bm_pkg::NUM_M-1:0][2:0]                 undefined_burst_limit,
    // Slave ports
    input  wire logic [bm_pkg::NUM_S-1:0]                      s_ready,
    output logic      [bm_pkg::NUM_S-1:0][bm_pkg::IDX_W-1:0]   s_owner,
    output logic      [bm_pkg::NUM_S-1:0]                      s_conn,
    // Slave configuration
    input  wire logic [bm_pkg::NUM_S-1:0][1:0]                 default_master_policy,
    input  wire logic [bm_pkg::NUM_S-1:0][bm_pkg::IDX_W-1:0]   fixed_master_select,
    input  wire logic [bm_pkg::NUM_S-1:0]                      arbitration_type_select,
    input  wire logic [bm_pkg::NUM_S-1:0][bm_pkg::SLOT_W-1:0]  slot_cycle,
    input  wire logic [bm_pkg::NUM_S-1:0][bm_pkg::REG_W-1:0]   slave_priority_a,
    input  wire logic [bm_pkg::NUM_S-1:0][bm_pkg::REG_W-1:0]   slave_priority_b
);

    // ****************************************************************
    // State
    // ****************************************************************

    typedef struct packed {
        logic [bm_pkg::NUM_S-1:0][bm_pkg::IDX_W-1:0]  owner;
        logic [bm_pkg::NUM_S-1:0]                     conn;
        logic [bm_pkg::NUM_S-1:0][bm_pkg::BEAT_W-1:0] beat;
        logic [bm_pkg::NUM_S-1:0][bm_pkg::SLOT_W-1:0] slot;
        logic [bm_pkg::NUM_S-1:0]                     in_burst;
        logic [bm_pkg::NUM_S-1:0][bm_pkg::IDX_W-1:0]  rr_ptr;
        logic                                         clk_run;
        logic                                         quiet;
    } state_s;

    state_s st_q;
    state_s st_d;

    logic [bm_pkg::NUM_M-1:0][bm_pkg::IDX_W-1:0] tgt;
    logic [bm_pkg::NUM_M-1:0]                    act;
    logic [bm_pkg::IDX_W-1:0]                    own;
    logic                                        own_on;
    logic [bm_pkg::BEAT_W-1:0]                   beat_now;
    logic [3:0]                                  mask;
    logic                                        endable;
    logic                                        accept;
    logic                                        burst_end;
    logic                                        slot_out;
    logic                                        arb_ok;
    logic [bm_pkg::NUM_M-1:0]                    req;
    logic [bm_pkg::IDX_W-1:0]                    win;
    logic [bm_pkg::IDX_W-1:0]                    idx;
    logic [bm_pkg::PRI_W-1:0]                    best;
    logic                                        found;

    // ****************************************************************
    // Helpers
    // ****************************************************************

    // Maps an address to a slave index, applying boot and remap choices.
    function automatic logic [bm_pkg::IDX_W-1:0] decode(
        input logic [bm_pkg::ADDR_W-1:0] addr,
        input logic                      remap,
        input logic                      boot_ext
    );
        logic [3:0] region;
        region = addr[bm_pkg::REG_HI:bm_pkg::REG_LO];
        if (region != bm_pkg::REGION_BOOT) begin
            return region;
        end else if (remap) begin
            return bm_pkg::REMAP_SLAVE;
        end else if (boot_ext) begin
            return bm_pkg::BOOT_EXT_SLAVE;
        end
        return bm_pkg::BOOT_INT_SLAVE;
    endfunction : decode

    // Priority of one master toward one slave, from register A or B.
    function automatic logic [bm_pkg::PRI_W-1:0] prio(
        input logic [bm_pkg::REG_W-1:0] pa,
        input logic [bm_pkg::REG_W-1:0] pb,
        input int                       m
    );
        if (m < bm_pkg::PRI_PER) begin
            return pa[m*bm_pkg::PRI_W +: bm_pkg::PRI_W];
        end
        return pb[(m-bm_pkg::PRI_PER)*bm_pkg::PRI_W +: bm_pkg::PRI_W];
    endfunction : prio

    // ****************************************************************
    // Decoders, one per master
    // ****************************************************************

    always_comb begin
        for (int m = 0; m < bm_pkg::NUM_M; m++) begin
            tgt[m] = decode(m_addr[m], master_remap_control[m], boot_ext_sel);
            act[m] = (m_trans[m] == bm_pkg::TR_NONSEQ) || (m_trans[m] == bm_pkg::TR_SEQ);
        end
    end

    // A master proceeds only while its target slave is connected to it.
    always_comb begin
        for (int m = 0; m < bm_pkg::NUM_M; m++) begin
            m_ready[m] = st_q.conn[tgt[m]] && (st_q.owner[tgt[m]] == bm_pkg::IDX_W'(m))
                         && s_ready[tgt[m]];
        end
    end

    // ****************************************************************
    // Arbiters, one per slave
    // ****************************************************************

    always_comb begin
        st_d      = st_q;
        own       = '0;
        own_on    = 1'b0;
        beat_now  = '0;
        mask      = bm_pkg::MASK_1;
        endable   = 1'b0;
        accept    = 1'b0;
        burst_end = 1'b0;
        slot_out  = 1'b0;
        arb_ok    = 1'b0;
        req       = '0;
        win       = '0;
        idx       = '0;
        best      = '0;
        found     = 1'b0;
        for (int s = 0; s < bm_pkg::NUM_S; s++) begin
            own    = st_q.owner[s];
            own_on = act[own] && (tgt[own] == bm_pkg::IDX_W'(s));
            if (m_trans[own] == bm_pkg::TR_NONSEQ) begin
                beat_now = bm_pkg::BEAT_ZERO;
            end else begin
                beat_now = st_q.beat[s];
            end

            // Beat length of the burst in progress; INCR uses the master's limit.
            endable = 1'b1;
            unique case (m_burst[own])
                bm_pkg::BURST_SINGLE: mask = bm_pkg::MASK_1;
                bm_pkg::BURST_INCR: begin
                    unique case (undefined_burst_limit[own])
                        bm_pkg::LIMIT_ONE:     mask = bm_pkg::MASK_1;
                        bm_pkg::LIMIT_FOUR:    mask = bm_pkg::MASK_4;
                        bm_pkg::LIMIT_EIGHT:   mask = bm_pkg::MASK_8;
                        bm_pkg::LIMIT_SIXTEEN: mask = bm_pkg::MASK_16;
                        default: begin
                            mask    = bm_pkg::MASK_16;
                            endable = 1'b0;
                        end
                    endcase
                end
                bm_pkg::BURST_WRAP4, bm_pkg::BURST_INCR4: mask = bm_pkg::MASK_4;
                bm_pkg::BURST_WRAP8, bm_pkg::BURST_INCR8: mask = bm_pkg::MASK_8;
                default:    mask = bm_pkg::MASK_16;
            endcase

            accept    = st_q.conn[s] && own_on && s_ready[s];
            burst_end = endable && ((beat_now & mask) == mask);
            slot_out  = st_q.in_burst[s] && (st_q.slot[s] == bm_pkg::SLOT_ZERO);
            arb_ok    = !st_q.conn[s] || !own_on
                        || (accept && (burst_end || slot_out));

            // Beat and slot bookkeeping for the connected master.
            if (accept) begin
                st_d.beat[s] = beat_now + bm_pkg::BEAT_ONE;
            end
            if (accept && (m_trans[own] == bm_pkg::TR_NONSEQ)) begin
                st_d.in_burst[s] = (m_burst[own] != bm_pkg::BURST_SINGLE);
                st_d.slot[s]     = slot_cycle[s];
            end else if (accept && slot_out) begin
                st_d.slot[s] = slot_cycle[s];
            end else if (st_q.in_burst[s] && !slot_out) begin
                st_d.slot[s] = st_q.slot[s] - bm_pkg::SLOT_ONE;
            end

            for (int m = 0; m < bm_pkg::NUM_M; m++) begin
                req[m] = matrix_en && act[m] && (tgt[m] == bm_pkg::IDX_W'(s));
            end

            // Winner: rotating search or highest priority value.
            found = 1'b0;
            best  = '0;
            win   = '0;
            if (arbitration_type_select[s] == bm_pkg::ARB_ROUND_ROBIN) begin
                for (int k = 0; k < bm_pkg::NUM_M; k++) begin
                    idx = st_q.rr_ptr[s] + bm_pkg::IDX_W'(k);
                    if (req[idx] && !found) begin
                        win   = idx;
                        found = 1'b1;
                    end
                end
            end else begin
                for (int m = 0; m < bm_pkg::NUM_M; m++) begin
                    if (req[m] && (!found
                        || prio(slave_priority_a[s], slave_priority_b[s], m) >= best)) begin
                        best  = prio(slave_priority_a[s], slave_priority_b[s], m);
                        win   = bm_pkg::IDX_W'(m);
                        found = 1'b1;
                    end
                end
            end

            // Ownership changes only here: when the owner is idle, its burst ends or its slot expires.
            if (arb_ok) begin
                if (found) begin
                    if (!st_q.conn[s] || (win != own)) begin
                        st_d.owner[s]    = win;
                        st_d.conn[s]     = 1'b1;
                        st_d.beat[s]     = bm_pkg::BEAT_ZERO;
                        st_d.in_burst[s] = 1'b0;
                    end
                    st_d.rr_ptr[s] = win + bm_pkg::IDX_ONE;
                end else begin
                    unique case (default_master_policy[s])
                        bm_pkg::DEF_LAST: begin
                            st_d.owner[s] = own;
                        end
                        bm_pkg::DEF_FIXED: begin
                            st_d.owner[s] = fixed_master_select[s];
                            st_d.conn[s]  = 1'b1;
                        end
                        default: begin
                            st_d.conn[s] = 1'b0;
                        end
                    endcase
                    st_d.in_burst[s] = 1'b0;
                end
                if (!matrix_en) begin
                    st_d.conn[s] = 1'b0;
                end
            end
        end

        // Power manager may stop the clock once running from reset.
        st_d.clk_run = !clk_stop_req;
        st_d.quiet   = !(|st_d.conn);
    end

    // ****************************************************************
    // Registers and outputs
    // ****************************************************************

    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q         <= '0;
            st_q.clk_run <= 1'b1;
            st_q.quiet   <= 1'b1;
        end else begin
            st_q <= st_d;
        end
    end

    assign s_owner      = st_q.owner;
    assign s_conn       = st_q.conn;
    assign clk_run      = st_q.clk_run;
    assign matrix_quiet = st_q.quiet;

    // sixteen decoders and sixteen arbiters are built above.

endmodule : bus_matrix

/* tb/bus_matrix_props.sv */
// Concurrent checks on the bus matrix ports.
`timescale 1ns/1ns
module bus_matrix_props (
    // Clock and reset
    input wire logic              clk_sys,
    input wire logic              srst,
    // Observed ports
    input wire logic              clk_stop_req,
    input wire logic              matrix_en,
    input wire logic              clk_run,
    input wire logic              matrix_quiet,
    input wire logic [15:0][1:0]  m_trans,
    input wire logic [15:0][31:0] m_addr,
    input wire logic [15:0]       m_ready,
    input wire logic [15:0]       s_ready,
    input wire logic [15:0][3:0]  s_owner,
    input wire logic [15:0]       s_conn,
    input wire logic [15:0][1:0]  default_master_policy,
    input wire logic [15:0][3:0]  fixed_master_select
);
    // **********************************
    // Properties
    // **********************************
    logic idle_all;
    assign idle_all = !(|m_trans);

    default clocking @(posedge clk_sys); endclocking
    default disable iff (srst);

    a_reset_vals: assert property (disable iff (1'b0) srst |=> s_conn == '0 && clk_run && matrix_quiet)
        else $error("reset state wrong");
    a_clk_follow: assert property (!$past(srst) |-> clk_run == !$past(clk_stop_req))
        else $error("clock run request wrong");
    a_quiet_match: assert property (matrix_quiet == (s_conn == '0))
        else $error("quiet flag wrong");

    for (genvar s = 0; s < 16; s++) begin : g_s
        a_none_drop: assert property (
            idle_all [*3] ##0 default_master_policy[s] == bm_pkg::DEF_NONE |-> !s_conn[s])
            else $error("idle slave still connected");
        a_last_keep: assert property (
            default_master_policy[s] == bm_pkg::DEF_LAST && idle_all
            && $past(idle_all) && $past(s_conn[s]) && $past(matrix_en)
            |-> s_conn[s] && s_owner[s] == $past(s_owner[s]))
            else $error("last master dropped");
        a_fixed_idle: assert property (
            (idle_all && matrix_en) [*3] ##0 default_master_policy[s] == bm_pkg::DEF_FIXED
            |-> s_conn[s] && s_owner[s] == fixed_master_select[s])
            else $error("fixed master not connected");
        a_burst_hold: assert property (
            s_conn[s] && m_trans[s_owner[s]] == bm_pkg::TR_SEQ && !m_ready[s_owner[s]]
            && m_addr[s_owner[s]][31:28] == 4'(s) |=> s_conn[s] && $stable(s_owner[s]))
            else $error("burst broken mid beat");
    end

    for (genvar m = 0; m < 16; m++) begin : g_m
        a_ready_route: assert property (
            m_ready[m] && m_trans[m][1] && m_addr[m][31:28] != 4'h0
            |-> s_conn[m_addr[m][31:28]] && s_owner[m_addr[m][31:28]] == m
            && s_ready[m_addr[m][31:28]])
            else $error("ready without connection");
    end

    cp_prio_win: cover property (s_conn[6] && s_owner[6] == 4'h9);
    cp_burst_break: cover property (s_owner[7] == 4'hA && $past(s_owner[7]) == 4'h3);
    cp_clk_stop: cover property ($fell(clk_run));
    cp_slot_break: cover property (s_owner[9] == 4'h1 && $past(s_owner[9]) == 4'h0);
endmodule : bus_matrix_props

/* tb/bus_matrix_test.sv */
// Self-checking bench for the bus matrix arbiter.
`timescale 1ns/1ns
module bus_matrix_test;
    // **********************************
    // Signals and instances
    // **********************************
    logic              clk_sys, srst, clk_stop_req, matrix_en, clk_run, matrix_quiet, boot_ext_sel;
    logic [15:0][1:0]  m_trans, default_master_policy;
    logic [15:0][2:0]  m_burst, undefined_burst_limit;
    logic [15:0][31:0] m_addr, slave_priority_a, slave_priority_b;
    logic [15:0]       m_ready, master_remap_control, s_ready, s_conn, arbitration_type_select, slow;
    logic [15:0][3:0]  s_owner, fixed_master_select;
    logic [15:0][7:0]  slot_cycle;
    int                bad_count, tests_run, n;

    bus_matrix DUT (.clk_sys, .srst, .clk_stop_req, .matrix_en, .clk_run, .matrix_quiet,
        .m_trans, .m_burst, .m_addr, .m_ready, .boot_ext_sel, .master_remap_control,
        .undefined_burst_limit, .s_ready, .s_owner, .s_conn, .default_master_policy,
        .fixed_master_select, .arbitration_type_select, .slot_cycle, .slave_priority_a,
        .slave_priority_b);
    slave_model u_slaves (.clk_sys, .srst, .slow, .s_conn, .s_ready);

    task automatic check(logic ok, string msg);
        tests_run++;
        if (ok !== 1'b1) begin
            bad_count++;
            $display("unexpected at %0t: %s", $time, msg);
        end
    endtask : check

    task automatic tick(int k);
        repeat (k) @(posedge clk_sys);
        #1;
    endtask : tick

    task automatic start(int m, logic [31:0] a, logic [2:0] b);
        m_trans[m] = bm_pkg::TR_NONSEQ;
        m_burst[m] = b;
        m_addr[m] = a;
    endtask : start

    // Counts the cycles a beat waits, then passes the edge that takes it.
    task automatic beat(int m, output int lat);
        lat = 0;
        @(negedge clk_sys);
        while (m_ready[m] !== 1'b1 && lat < 50) begin
            lat++;
            @(negedge clk_sys);
        end
        tick(1);
    endtask : beat

    task automatic xfer(int m, logic [31:0] a, int exp);
        start(m, a, bm_pkg::BURST_SINGLE);
        beat(m, n);
        m_trans[m] = bm_pkg::TR_IDLE;
        check(n == exp, "latency");
    endtask : xfer

    task automatic print_verdict();
        if (bad_count == 0 && tests_run > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask : print_verdict

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    initial begin
        #400000;
        bad_count++;
        print_verdict();
    end

    // **********************************
    // Test sequence
    // **********************************
    initial begin
        srst = 1'b1;
        clk_stop_req = 1'b0;
        matrix_en = 1'b1;
        boot_ext_sel = 1'b0;
        m_trans = '0;
        m_burst = '0;
        m_addr = '0;
        slow = 16'h2000;
        master_remap_control = 16'h0040;
        undefined_burst_limit = '0;
        undefined_burst_limit[3] = bm_pkg::LIMIT_FOUR;
        default_master_policy = '0;
        default_master_policy[0] = bm_pkg::DEF_LAST;
        default_master_policy[1] = bm_pkg::DEF_LAST;
        default_master_policy[3] = bm_pkg::DEF_LAST;
        default_master_policy[14] = bm_pkg::DEF_LAST;
        default_master_policy[4] = bm_pkg::DEF_FIXED;
        fixed_master_select = '0;
        fixed_master_select[4] = 4'h5;
        arbitration_type_select = 16'h0040;
        slot_cycle = {16{8'h40}};
        slot_cycle[9] = 8'h03;
        slave_priority_a = '0;
        slave_priority_a[6] = 32'h00000300;
        slave_priority_b = '0;
        slave_priority_b[6] = 32'h00020030;
        tick(12);
        srst = 1'b0;
        check(clk_run === 1'b1 && matrix_quiet === 1'b1 && s_conn === 16'h0000, "reset");
        tick(3);
        check(s_conn[4] === 1'b1 && s_owner[4] === 4'h5, "fixed idle");
        xfer(3, 32'h20000010, 1);
        tick(3);
        check(s_conn[2] === 1'b0, "slave kept");
        xfer(4, 32'h30000000, 1);
        tick(1);
        check(s_owner[3] === 4'h4 && s_conn[3] === 1'b1, "last master lost");
        xfer(4, 32'h30000004, 0);
        xfer(8, 32'h30000008, 1);
        xfer(5, 32'h40000000, 0);
        xfer(2, 32'h40000000, 1);
        tick(3);
        check(s_owner[4] === 4'h5, "fixed master lost");
        xfer(6, 32'h00000100, 1);
        xfer(7, 32'h00000100, 1);
        tick(1);
        check(s_owner[1] === 4'h6 && s_owner[0] === 4'h7 && s_conn[1] === 1'b1, "remap");
        boot_ext_sel = 1'b1;
        xfer(7, 32'h00000100, 1);
        tick(1);
        check(s_conn[14] === 1'b1 && s_owner[14] === 4'h7, "boot route");
        boot_ext_sel = 1'b0;
        start(6, 32'h50000000, bm_pkg::BURST_SINGLE);
        start(1, 32'h50000000, bm_pkg::BURST_SINGLE);
        beat(1, n);
        m_trans[1] = bm_pkg::TR_IDLE;
        check(n == 1, "lowest first");
        xfer(6, 32'h50000000, 0);
        tick(1);
        start(1, 32'h50000000, bm_pkg::BURST_SINGLE);
        start(9, 32'h50000000, bm_pkg::BURST_SINGLE);
        beat(9, n);
        m_trans[9] = bm_pkg::TR_IDLE;
        check(n == 1, "rotation");
        xfer(1, 32'h50000000, 0);
        start(2, 32'h60000000, bm_pkg::BURST_SINGLE);
        start(12, 32'h60000000, bm_pkg::BURST_SINGLE);
        start(9, 32'h60000000, bm_pkg::BURST_SINGLE);
        beat(9, n);
        m_trans[9] = bm_pkg::TR_IDLE;
        check(n == 1, "priority tie");
        xfer(2, 32'h60000000, 1);
        xfer(12, 32'h60000000, 1);
        start(3, 32'h70000000, bm_pkg::BURST_INCR);
        beat(3, n);
        m_trans[3] = bm_pkg::TR_SEQ;
        start(10, 32'h70000000, bm_pkg::BURST_SINGLE);
        repeat (3) beat(3, n);
        check(n == 0, "burst broken early");
        beat(10, n);
        check(n == 0, "predicted end");
        m_trans[10] = bm_pkg::TR_IDLE;
        m_trans[3] = bm_pkg::TR_IDLE;
        start(11, 32'hD0000000, bm_pkg::BURST_INCR);
        beat(11, n);
        m_trans[11] = bm_pkg::TR_SEQ;
        beat(11, n);
        m_trans[11] = bm_pkg::TR_IDLE;
        check(n == 1, "slow slave beat");
        start(0, 32'h90000000, bm_pkg::BURST_INCR);
        beat(0, n);
        m_trans[0] = bm_pkg::TR_SEQ;
        start(1, 32'h90000000, bm_pkg::BURST_SINGLE);
        repeat (4) beat(0, n);
        check(n == 0, "slot held");
        beat(1, n);
        m_trans[1] = bm_pkg::TR_IDLE;
        m_trans[0] = bm_pkg::TR_IDLE;
        check(n == 0, "slot expiry");
        tick(1);
        matrix_en = 1'b0;
        tick(1);
        clk_stop_req = 1'b1;
        start(3, 32'h20000000, bm_pkg::BURST_SINGLE);
        tick(4);
        check(clk_run === 1'b0 && m_ready[3] === 1'b0 && s_conn[2] === 1'b0, "stop");
        clk_stop_req = 1'b0;
        matrix_en = 1'b1;
        beat(3, n);
        m_trans[3] = bm_pkg::TR_IDLE;
        check(n == 1 && clk_run === 1'b1, "restart");
        tick(5);
        print_verdict();
    end
endmodule : bus_matrix_test

bind bus_matrix bus_matrix_props u_props (.clk_sys, .srst, .clk_stop_req, .matrix_en, .clk_run,
    .matrix_quiet, .m_trans, .m_addr, .m_ready, .s_ready, .s_owner, .s_conn,
    .default_master_policy, .fixed_master_select);

/* tb/slave_model.sv */
// Slave port model that answers at once or only on alternate cycles.
`timescale 1ns/1ns
module slave_model (
    // Clock and reset
    input  wire logic        clk_sys,
    input  wire logic        srst,
    // Slave side
    input  wire logic [15:0] slow,
    input  wire logic [15:0] s_conn,
    output logic      [15:0] s_ready
);
    // **********************************
    // Ready generation
    // **********************************
    logic toggle_q;

    always_ff @(posedge clk_sys) begin
        toggle_q <= srst ? 1'b0 : !toggle_q;
    end

    // An unselected or slow slave shows a level that changes every cycle, held at 0 only while srst is high.
    always_comb begin
        for (int i = 0; i < 16; i++) begin
            s_ready[i] = (s_conn[i] && !slow[i]) ? 1'b1 : toggle_q;
        end
    end
endmodule : slave_model
